/* File: rtl/alert_cause_status_register.sv */
// Alert cause status register: sticky flags, clear after read plus conversion
module alert_cause_status_register #(
	parameter int NUM_CH = alert_cause_pkg::NUM_CH
) (
	input  wire logic                  clk_sys,
	input  wire logic                  rstn,
	input  wire logic                  conv_done,
	input  wire alert_cause_pkg::cause_s cause,
	input  wire alert_cause_pkg::cause_s cause_enable,
	input  wire logic                  reg_rd,
	input  wire logic [7:0]            reg_addr,
	output logic [23:0]                reg_rdata,
	output logic                       reg_rvalid,
	output logic                       alert
);
	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (NUM_CH != alert_cause_pkg::NUM_CH) begin : g_bad_ch
		$error("channel count must be four");
	end
	if ($bits(alert_cause_pkg::cause_s) != alert_cause_pkg::NUM_SRC) begin : g_bad_src
		$error("source count does not match the cause record");
	end
	if (alert_cause_pkg::OC_LSB + NUM_CH != alert_cause_pkg::REG_W) begin : g_bad_top
		$error("overcurrent field must end at the top bit");
	end
	if (alert_cause_pkg::UC_LSB + NUM_CH != alert_cause_pkg::OC_LSB) begin : g_bad_uc
		$error("undercurrent field must sit below overcurrent");
	end
	if (alert_cause_pkg::OV_LSB + NUM_CH != alert_cause_pkg::UC_LSB) begin : g_bad_ov
		$error("overvoltage field must sit below undercurrent");
	end
	if (alert_cause_pkg::UV_LSB + NUM_CH != alert_cause_pkg::OV_LSB) begin : g_bad_uv
		$error("undervoltage field must sit below overvoltage");
	end
	if (alert_cause_pkg::OP_LSB + NUM_CH != alert_cause_pkg::UV_LSB) begin : g_bad_op
		$error("overpower field must sit below undervoltage");
	end
	if (alert_cause_pkg::ACC_BIT <= alert_cause_pkg::CNT_BIT ||
		alert_cause_pkg::ACC_BIT >= alert_cause_pkg::OP_LSB) begin : g_bad_acc
		$error("accumulator flags must sit between overpower and the unused bits");
	end
	if ($bits(alert_cause_pkg::UNIMP_VAL) != alert_cause_pkg::CNT_BIT) begin : g_bad_unimp
		$error("unused field must fill the bits below the count flag");
	end

	// ----------------------------------------
	// Source mapping into register layout
	// ----------------------------------------
	localparam int SRC_LSB = alert_cause_pkg::CNT_BIT;

	// Register bit of a channel flag, index 0 is channel 1
	function automatic int field_bit(input int lsb, input int idx);
		return lsb + NUM_CH - 1 - idx;
	endfunction

	function automatic logic [23:0] pack_cause(input alert_cause_pkg::cause_s c);
		logic [23:0] v;
		v = alert_cause_pkg::ALERT_CAUSE_RST;
		for (int i = 0; i < NUM_CH; i++) begin
			v[field_bit(alert_cause_pkg::OC_LSB, i)] = c.over_current[i];
			v[field_bit(alert_cause_pkg::UC_LSB, i)] = c.under_current[i];
			v[field_bit(alert_cause_pkg::OV_LSB, i)] = c.over_voltage[i];
			v[field_bit(alert_cause_pkg::UV_LSB, i)] = c.under_voltage[i];
			v[field_bit(alert_cause_pkg::OP_LSB, i)] = c.over_power[i];
		end
		v[alert_cause_pkg::ACC_BIT] = c.accum_full;
		v[alert_cause_pkg::CNT_BIT] = c.count_full;
		return v;
	endfunction

	logic [23:0] cond_vec;
	logic [23:0] en_vec;
	logic [23:0] flag_vec;
	logic        hit_rd;

	assign cond_vec = pack_cause(cause);
	assign en_vec   = pack_cause(cause_enable);
	assign hit_rd   = reg_rd && (reg_addr == alert_cause_pkg::ALERT_CAUSE_ADR);

	// ----------------------------------------
	// Read-arm tracking
	// ----------------------------------------
	alert_cause_pkg::clr_state_e clr_state_ff;
	alert_cause_pkg::clr_state_e nxt_clr_state;

	always_comb begin
		nxt_clr_state = clr_state_ff;
		case (clr_state_ff)
			alert_cause_pkg::ST_IDLE: begin
				// Any read, with or without conv_done, arms for the next conversion
				if (hit_rd)
					nxt_clr_state = alert_cause_pkg::ST_ARMED;
			end
			alert_cause_pkg::ST_ARMED: begin
				// Read during the clearing conversion re-arms for the next one
				if (conv_done && !hit_rd)
					nxt_clr_state = alert_cause_pkg::ST_IDLE;
			end
			default: nxt_clr_state = alert_cause_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			clr_state_ff <= alert_cause_pkg::ST_IDLE;
		else
			clr_state_ff <= nxt_clr_state;
	end

	// ----------------------------------------
	// Flag array
	// ----------------------------------------
	assign flag_vec[SRC_LSB-1:0] = alert_cause_pkg::UNIMP_VAL;

	for (genvar b = SRC_LSB; b < alert_cause_pkg::REG_W; b++) begin : g_flag
		cause_flag_bit u_flag (
			.clk_sys     (clk_sys),
			.rstn        (rstn),
			.conv_done   (conv_done),
			.cond        (cond_vec[b]),
			.enable      (en_vec[b]),
			.clear_armed (clr_state_ff == alert_cause_pkg::ST_ARMED),
			.flag        (flag_vec[b])
		);
	end

	// ----------------------------------------
	// Named flag views
	// ----------------------------------------
	logic        ch1_over_current_flag;
	logic        ch2_over_current_flag;
	logic        ch3_over_current_flag;
	logic        ch4_over_current_flag;
	logic        ch1_under_current_flag;
	logic        ch2_under_current_flag;
	logic        ch3_under_current_flag;
	logic        ch4_under_current_flag;
	logic        ch1_over_voltage_flag;
	logic        ch2_over_voltage_flag;
	logic        ch3_over_voltage_flag;
	logic        ch4_over_voltage_flag;
	logic        ch1_under_voltage_flag;
	logic        ch2_under_voltage_flag;
	logic        ch3_under_voltage_flag;
	logic        ch4_under_voltage_flag;
	logic        ch1_over_power_flag;
	logic        ch2_over_power_flag;
	logic        ch3_over_power_flag;
	logic        ch4_over_power_flag;
	logic        accumulator_full_flag;
	logic        sample_counter_full_flag;
	logic [23:0] read_word;

	assign ch1_over_current_flag    = flag_vec[field_bit(alert_cause_pkg::OC_LSB, 0)];
	assign ch2_over_current_flag    = flag_vec[field_bit(alert_cause_pkg::OC_LSB, 1)];
	assign ch3_over_current_flag    = flag_vec[field_bit(alert_cause_pkg::OC_LSB, 2)];
	assign ch4_over_current_flag    = flag_vec[field_bit(alert_cause_pkg::OC_LSB, 3)];
	assign ch1_under_current_flag   = flag_vec[field_bit(alert_cause_pkg::UC_LSB, 0)];
	assign ch2_under_current_flag   = flag_vec[field_bit(alert_cause_pkg::UC_LSB, 1)];
	assign ch3_under_current_flag   = flag_vec[field_bit(alert_cause_pkg::UC_LSB, 2)];
	assign ch4_under_current_flag   = flag_vec[field_bit(alert_cause_pkg::UC_LSB, 3)];
	assign ch1_over_voltage_flag    = flag_vec[field_bit(alert_cause_pkg::OV_LSB, 0)];
	assign ch2_over_voltage_flag    = flag_vec[field_bit(alert_cause_pkg::OV_LSB, 1)];
	assign ch3_over_voltage_flag    = flag_vec[field_bit(alert_cause_pkg::OV_LSB, 2)];
	assign ch4_over_voltage_flag    = flag_vec[field_bit(alert_cause_pkg::OV_LSB, 3)];
	assign ch1_under_voltage_flag   = flag_vec[field_bit(alert_cause_pkg::UV_LSB, 0)];
	assign ch2_under_voltage_flag   = flag_vec[field_bit(alert_cause_pkg::UV_LSB, 1)];
	assign ch3_under_voltage_flag   = flag_vec[field_bit(alert_cause_pkg::UV_LSB, 2)];
	assign ch4_under_voltage_flag   = flag_vec[field_bit(alert_cause_pkg::UV_LSB, 3)];
	assign ch1_over_power_flag      = flag_vec[field_bit(alert_cause_pkg::OP_LSB, 0)];
	assign ch2_over_power_flag      = flag_vec[field_bit(alert_cause_pkg::OP_LSB, 1)];
	assign ch3_over_power_flag      = flag_vec[field_bit(alert_cause_pkg::OP_LSB, 2)];
	assign ch4_over_power_flag      = flag_vec[field_bit(alert_cause_pkg::OP_LSB, 3)];
	assign accumulator_full_flag    = flag_vec[alert_cause_pkg::ACC_BIT];
	assign sample_counter_full_flag = flag_vec[alert_cause_pkg::CNT_BIT];

	// Read word in register order, channel 1 highest in each field
	assign read_word = {
		ch1_over_current_flag,
		ch2_over_current_flag,
		ch3_over_current_flag,
		ch4_over_current_flag,
		ch1_under_current_flag,
		ch2_under_current_flag,
		ch3_under_current_flag,
		ch4_under_current_flag,
		ch1_over_voltage_flag,
		ch2_over_voltage_flag,
		ch3_over_voltage_flag,
		ch4_over_voltage_flag,
		ch1_under_voltage_flag,
		ch2_under_voltage_flag,
		ch3_under_voltage_flag,
		ch4_under_voltage_flag,
		ch1_over_power_flag,
		ch2_over_power_flag,
		ch3_over_power_flag,
		ch4_over_power_flag,
		accumulator_full_flag,
		sample_counter_full_flag,
		alert_cause_pkg::UNIMP_VAL
	};

	// ----------------------------------------
	// Read port and alert output
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rstn)
			reg_rdata <= alert_cause_pkg::ALERT_CAUSE_RST;
		else if (hit_rd)
			reg_rdata <= read_word;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			reg_rvalid <= 1'b0;
		else
			reg_rvalid <= hit_rd;
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			alert <= 1'b0;
		else
			alert <= |flag_vec;
	end
endmodule

/* File: rtl/alert_cause_pkg.sv */
// Package: offsets, field layout and constants of the alert cause register
package alert_cause_pkg;
	localparam int          NUM_CH          = 4;
	localparam int          REG_W           = 24;
	localparam logic [7:0]  ALERT_CAUSE_ADR = 8'h26;
	localparam logic [23:0] ALERT_CAUSE_RST = 24'h000000;
	localparam int          OC_LSB          = 20;
	localparam int          UC_LSB          = 16;
	localparam int          OV_LSB          = 12;
	localparam int          UV_LSB          = 8;
	localparam int          OP_LSB          = 4;
	localparam int          ACC_BIT         = 3;
	localparam int          CNT_BIT         = 2;
	localparam int          NUM_SRC         = 22;
	localparam logic [1:0]  UNIMP_VAL       = 2'h0;

	// Per-channel comparator results plus accumulator and counter full, index 0 is channel 1
	typedef struct packed {
		logic [3:0] over_current;
		logic [3:0] under_current;
		logic [3:0] over_voltage;
		logic [3:0] under_voltage;
		logic [3:0] over_power;
		logic       accum_full;
		logic       count_full;
	} cause_s;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_ARMED   = 2'b01
	} clr_state_e;
endpackage

/* File: rtl/cause_flag_bit.sv */
// One sticky cause flag with read-armed clear on conversion completion
module cause_flag_bit (
	input  wire logic clk_sys,
	input  wire logic rstn,
	input  wire logic conv_done,
	input  wire logic cond,
	input  wire logic enable,
	input  wire logic clear_armed,
	output logic      flag
);
	logic flag_ff;
	logic nxt_flag;

	always_comb begin
		nxt_flag = flag_ff;
		if (conv_done) begin
			if (enable && cond)
				nxt_flag = 1'b1;
			else if (clear_armed)
				nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn)
			flag_ff <= 1'b0;
		else
			flag_ff <= nxt_flag;
	end

	assign flag = flag_ff;
endmodule

/* File: tb/alert_cause_chk.sv */
// Port assertions for the alert cause register
module alert_cause_chk (
	input wire logic                    clk_sys,
	input wire logic                    rstn,
	input wire logic                    conv_done,
	input wire logic                    reg_rd,
	input wire logic                    reg_rvalid,
	input wire logic                    alert,
	input wire logic [7:0]              reg_addr,
	input wire logic [23:0]             reg_rdata,
	input wire alert_cause_pkg::cause_s cause,
	input wire alert_cause_pkg::cause_s cause_enable
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire logic hit = reg_rd && reg_addr == 8'h26;
	chk_read_answer: assert property (hit |=> reg_rvalid) else $error("no answer");
	chk_stray_valid: assert property (!hit |=> !reg_rvalid) else $error("stray");
	chk_unused_zero: assert property (reg_rdata[1:0] == 2'h0) else $error("low bits");
	chk_data_held: assert property (!reg_rvalid |-> $stable(reg_rdata)) else $error("data moved");
	chk_set_timing: assert property ($rose(alert) |-> $past(conv_done, 2)) else $error("set");
	chk_clear_timing: assert property ($fell(alert) |-> $past(conv_done, 2)) else $error("clear");
	chk_cause_sets: assert property (conv_done && |(cause & cause_enable) |-> ##2 alert) else $error("lost");
	chk_off_quiet: assert property (conv_done && !(|(cause & cause_enable))
		&& !alert && !$past(conv_done) |-> ##2 !alert) else $error("off");
endmodule
bind alert_cause_status_register alert_cause_chk chk (.*);

/* File: tb/alert_host.sv */
// Host model: register reads
module alert_host (
	input  wire logic        clk_sys,
	input  wire logic        reg_rvalid,
	input  wire logic [23:0] reg_rdata,
	output logic             reg_rd,
	output logic [7:0]       reg_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {reg_rd, reg_addr} = 9'h0;
	task automatic rd(input logic [7:0] a, output logic [23:0] d, output logic v);
		@(negedge clk_sys);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk_sys);
		{reg_rd, reg_addr, v, d} = {1'b0, ~a, reg_rvalid, reg_rdata};
	endtask
endmodule

/* File: tb/tb_alert_cause_status_register.sv */
// Bench for the alert cause register
module tb_alert_cause_status_register;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, rstn = 1'b0, conv_done = 1'b0, v;
	alert_cause_pkg::cause_s cause = '0, cause_enable = '0;
	wire logic reg_rd, reg_rvalid, alert;
	wire logic [7:0] reg_addr;
	wire logic [23:0] reg_rdata;
	logic [23:0] d;
	int err_count = 0, total_checks = 0, cyc = 0;
	always #20 clk_sys = ~clk_sys;
	alert_cause_status_register uut (.*);
	alert_host host (.*);
	task automatic chk(input logic [23:0] got, exp);
		total_checks++;
		if (got !== exp) err_count++;
		if (got !== exp) $display("BAD %0t %h %h", $time, got, exp);
	endtask
	task automatic conv(input logic [21:0] c);
		@(negedge clk_sys);
		{cause, conv_done} = {c, 1'b1};
		@(negedge clk_sys);
		{cause, conv_done} = {~c, 1'b0};
	endtask
	task automatic rdx(input logic [23:0] exp);
		host.rd(8'h26, d, v);
		chk(d, exp);
		chk({23'h0, v}, 24'h1);
	endtask
	task automatic stop_test;
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (++cyc == 2000) err_count++;
		if (cyc == 2000) stop_test();
	end
	initial begin
		repeat (8) @(negedge clk_sys);
		rstn = 1'b1;
		conv(22'h3FFFFF);
		rdx(24'h0);
		chk({23'h0, alert}, 24'h0);
		cause_enable = 22'h3FFFFF;
		for (int j = 0; j < 22; j++) begin
			conv(22'h1 << j);
			rdx(24'h1 << ((j < 2) ? j + 2 : 41 - 8 * ((21 - j) / 4) - j));
			chk({23'h0, alert}, 24'h1);
			conv(22'h0);
		end
		conv(22'h020000);
		conv(22'h0);
		rdx(24'h010000);
		rdx(24'h010000);
		conv(22'h020000);
		rdx(24'h010000);
		conv(22'h0);
		rdx(24'h0);
		chk({23'h0, alert}, 24'h0);
		conv(22'h0);
		fork
			conv(22'h020000);
			host.rd(8'h26, d, v);
		join
		chk(d, 24'h0);
		conv(22'h0);
		rdx(24'h0);
		host.rd(8'h27, d, v);
		chk({23'h0, v}, 24'h0);
		stop_test();
	end
endmodule
